// File: logic/bae_exec.sv
// execution datapath: add_acc_to_file, and_acc_with_file,
// and_literal_into_acc, clear_file_bit
// assumes the file port answers read data in the same clock as rd,
// and that instr_i is stable while the phase counter sits in Q1
//
// Operation
// - and_literal_into_acc ands the accumulator with the 8-bit literal and writes it in Q4.
// - add_acc_to_file (00 0111) sums accumulator and file in one cycle, updating C, half-carry, Z.
// - and_acc_with_file (00 0101) ands accumulator and file in one cycle, touching only Z.
// - byte file instructions send the result to the accumulator when d is 0, else to the file.
// - clear_file_bit (01 00bb) zeroes bit b of the file register and leaves all flags alone.
// - each instruction runs decode Q1, read Q2, compute Q3, write Q4.
// - a read of an i/o port register takes the pin levels, not the output latch.
`timescale 1ns/100ps

module bae_exec
  import bae_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire logic [IW_W-1:0]       instr_i,
  input  wire logic [DW-1:0]         file_rdata_i,
  input  wire logic [DW-1:0]         pins_a_i,
  input  wire logic [DW-1:0]         pins_b_i,
  output      bae_file_req_t         file_o,
  output      logic [DW-1:0]         acc_o,
  output      bae_flags_t            flags_o,
  output      logic [1:0]            phase_o,
  output      logic                  done_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0]    phase;
    bae_op_t       op;
    logic          dest;
    logic [2:0]    bit_sel;
    logic [AW-1:0] addr;
    logic [DW-1:0] lit;
    logic [DW-1:0] operand;
    logic [DW-1:0] result;
    bae_flags_t    pend;
    bae_flags_t    flags;
    logic [DW-1:0] acc;
    logic [DW-1:0] pa_meta;
    logic [DW-1:0] pa_sync;
    logic [DW-1:0] pb_meta;
    logic [DW-1:0] pb_sync;
  } bae_state_t;

  bae_state_t st_reg;
  bae_state_t st_next;

  logic [DW:0]   add9;
  logic [4:0]    add5;
  logic          uses_file;
  logic          to_file;
  logic          is_port_a;
  logic          is_port_b;
  logic [DW-1:0] bclr_mask;

  // ****************************************
  // combinational helpers
  // ****************************************
  assign add9      = {1'b0, st_reg.acc} + {1'b0, st_reg.operand};
  assign add5      = {1'b0, st_reg.acc[3:0]} + {1'b0, st_reg.operand[3:0]};
  assign uses_file = (st_reg.op == BAE_OP_ADDF) || (st_reg.op == BAE_OP_ANDF)
                     || (st_reg.op == BAE_OP_BCLR);
  // clear_file_bit always writes back; byte ops follow d
  assign to_file   = (st_reg.op == BAE_OP_BCLR)
                     || (uses_file && (st_reg.dest != DEST_ACC));
  assign is_port_a = (st_reg.addr == PORT_A_ADDR);
  assign is_port_b = (st_reg.addr == PORT_B_ADDR);
  assign bclr_mask = ~(8'h01 << st_reg.bit_sel);

  always_comb begin
    st_next = st_reg;
    // pins come from outside the clock domain: two flops first
    st_next.pa_meta = pins_a_i;
    st_next.pa_sync = st_reg.pa_meta;
    st_next.pb_meta = pins_b_i;
    st_next.pb_sync = st_reg.pb_meta;
    st_next.phase   = st_reg.phase + 2'h1;
    case (st_reg.phase)
      PH_Q1: begin
        // decode
        st_next.dest    = instr_i[BYTE_DEST];
        st_next.bit_sel = instr_i[BIT_SEL_HI:BIT_SEL_LO];
        st_next.addr    = instr_i[ADDR_HI:0];
        st_next.lit     = instr_i[LIT_HI:0];
        if (instr_i[OPC_HI:OPC_LO] == OPC_ADD_FILE) begin
          st_next.op = BAE_OP_ADDF;
        end else if (instr_i[OPC_HI:OPC_LO] == OPC_AND_FILE) begin
          st_next.op = BAE_OP_ANDF;
        end else if (instr_i[OPC_HI:OPC_LO] == OPC_AND_LIT) begin
          st_next.op = BAE_OP_ANDL;
        end else if (instr_i[OPC_HI:OPC_HI-3] == OPC_BCLR_TOP) begin
          st_next.op = BAE_OP_BCLR;
        end else begin
          st_next.op = BAE_OP_NONE;
        end
      end
      PH_Q2: begin
        // read operand; ports give the pin level, not the latch
        if (is_port_a) begin
          st_next.operand = st_reg.pa_sync;
        end else if (is_port_b) begin
          st_next.operand = st_reg.pb_sync;
        end else begin
          st_next.operand = file_rdata_i;
        end
      end
      PH_Q3: begin
        st_next.pend = st_reg.flags;
        case (st_reg.op)
          BAE_OP_ADDF: begin
            st_next.result               = add9[DW-1:0];
            st_next.pend.carry           = add9[DW];
            st_next.pend.half_carry_flag = add5[4];
            st_next.pend.zero            = (add9[DW-1:0] == 8'h00);
          end
          BAE_OP_ANDF: begin
            st_next.result    = st_reg.acc & st_reg.operand;
            st_next.pend.zero = ((st_reg.acc & st_reg.operand) == 8'h00);
          end
          BAE_OP_ANDL: begin
            st_next.result = st_reg.acc & st_reg.lit;
          end
          BAE_OP_BCLR: begin
            st_next.result = st_reg.operand & bclr_mask;
          end
          default: begin
            st_next.result = st_reg.acc;
          end
        endcase
      end
      PH_Q4: begin
        // write back; the file write itself is the file_o.wr strobe
        st_next.flags = st_reg.pend;
        if ((st_reg.op == BAE_OP_ANDL) || (uses_file && !to_file)) begin
          st_next.acc = st_reg.result;
        end
      end
      default: begin
        st_next.phase = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_reg       <= '0;
      st_reg.phase <= PH_Q1;
      st_reg.op    <= BAE_OP_NONE;
      st_reg.acc   <= ACC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // rd is not issued for port addresses: pins are used instead
  assign file_o.addr  = st_reg.addr;
  assign file_o.rd    = (st_reg.phase == PH_Q2) && uses_file
                        && !is_port_a && !is_port_b;
  assign file_o.wr    = (st_reg.phase == PH_Q4) && to_file;
  assign file_o.wdata = st_reg.result;
  assign acc_o        = st_reg.acc;
  assign flags_o      = st_reg.flags;
  assign phase_o      = st_reg.phase;
  assign done_o       = (st_reg.phase == PH_Q4);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  AST_PHASE_ORDER: assert property (
    (st_reg.phase == PH_Q1) |=> (st_reg.phase == PH_Q2) ##1 (st_reg.phase == PH_Q3)
      ##1 (st_reg.phase == PH_Q4) ##1 (st_reg.phase == PH_Q1))
    else $error("phase sequence broken");

  AST_READ_IN_Q2: assert property (
    file_o.rd |-> (st_reg.phase == PH_Q2) && !file_o.wr)
    else $error("file read outside Q2");

  AST_AND_LIT: assert property (
    (st_reg.phase == PH_Q3 && st_reg.op == BAE_OP_ANDL)
      |-> ##2 (acc_o == ($past(st_reg.acc, 2) & $past(st_reg.lit, 2))) && !$past(file_o.wr))
    else $error("literal and result wrong");

  AST_ADD_FLAGS: assert property (
    (st_reg.phase == PH_Q3 && st_reg.op == BAE_OP_ADDF)
      |-> ##2 (flags_o.carry == (({1'b0, $past(st_reg.acc, 2)}
                                  + {1'b0, $past(st_reg.operand, 2)}) > 9'h0FF))
      && (flags_o.half_carry_flag == (({1'b0, $past(st_reg.acc[3:0], 2)}
                                  + {1'b0, $past(st_reg.operand[3:0], 2)}) > 5'h0F))
      && (flags_o.zero == (($past(st_reg.acc, 2) + $past(st_reg.operand, 2)) == 8'h00)))
    else $error("add flags wrong");

  AST_ADD_SUM: assert property (
    (st_reg.phase == PH_Q3 && st_reg.op == BAE_OP_ADDF)
      |=> (file_o.wdata == $past(st_reg.acc) + $past(st_reg.operand)))
    else $error("add sum wrong");

  AST_ANDF_FLAGS: assert property (
    (st_reg.phase == PH_Q4 && st_reg.op == BAE_OP_ANDF)
      |=> (flags_o.carry == $past(flags_o.carry))
      && (flags_o.half_carry_flag == $past(flags_o.half_carry_flag))
      && (flags_o.zero == ($past(st_reg.result) == 8'h00)))
    else $error("and with file flags wrong");

  AST_DEST_SEL: assert property (
    (st_reg.phase == PH_Q4 && (st_reg.op == BAE_OP_ADDF || st_reg.op == BAE_OP_ANDF))
      |-> (file_o.wr == st_reg.dest) ##1 (st_reg.dest || acc_o == $past(st_reg.result)))
    else $error("destination select wrong");

  AST_BIT_CLEAR: assert property (
    (st_reg.phase == PH_Q4 && st_reg.op == BAE_OP_BCLR)
      |-> file_o.wr && (file_o.wdata[st_reg.bit_sel] == 1'b0)
      && ((file_o.wdata | ~bclr_mask) == (st_reg.operand | ~bclr_mask))
      ##1 $stable(flags_o) && $stable(acc_o))
    else $error("bit clear wrong");

  AST_PORT_PINS: assert property (
    (st_reg.phase == PH_Q2 && uses_file && is_port_a)
      |=> (st_reg.operand == $past(st_reg.pa_sync)))
    else $error("port read did not use pins");

  COV_ADD_TO_FILE: cover property (
    st_reg.phase == PH_Q4 && st_reg.op == BAE_OP_ADDF && file_o.wr);
  COV_ADD_CARRY: cover property (
    st_reg.phase == PH_Q3 && st_reg.op == BAE_OP_ADDF && add9[DW]);
  COV_AND_LIT: cover property (st_reg.phase == PH_Q4 && st_reg.op == BAE_OP_ANDL);
  COV_BCLR_PORT: cover property (
    st_reg.phase == PH_Q4 && st_reg.op == BAE_OP_BCLR && is_port_b);

endmodule

// File: logic/bae_pkg.sv
// package for the byte add / and / bit-clear execution datapath
// assumes one core clock, four clocks make one instruction cycle
package bae_pkg;

  // ****************************************
  // instruction word layout
  // ****************************************
  localparam int IW_W        = 14;
  localparam int DW          = 8;
  localparam int AW          = 7;
  localparam int OPC_HI      = 13;
  localparam int OPC_LO      = 8;
  localparam int BYTE_DEST   = 7;
  localparam int BIT_SEL_HI  = 9;
  localparam int BIT_SEL_LO  = 7;
  localparam int ADDR_HI     = 6;
  localparam int LIT_HI      = 7;

  // ****************************************
  // opcode patterns, upper bits of the word
  // ****************************************
  localparam logic [5:0] OPC_ADD_FILE  = 6'h07;
  localparam logic [5:0] OPC_AND_FILE  = 6'h05;
  localparam logic [5:0] OPC_AND_LIT   = 6'h39;
  localparam logic [3:0] OPC_BCLR_TOP  = 4'h4;
  localparam logic       DEST_ACC      = 1'b0;

  // ****************************************
  // i/o port register addresses
  // ****************************************
  localparam logic [AW-1:0] PORT_A_ADDR = 7'h05;
  localparam logic [AW-1:0] PORT_B_ADDR = 7'h06;

  // ****************************************
  // phases and reset values
  // ****************************************
  localparam logic [1:0]    PH_Q1     = 2'h0;
  localparam logic [1:0]    PH_Q2     = 2'h1;
  localparam logic [1:0]    PH_Q3     = 2'h2;
  localparam logic [1:0]    PH_Q4     = 2'h3;
  localparam logic [DW-1:0] ACC_RST   = 8'h00;

  typedef enum logic [2:0] {
    BAE_OP_NONE   = 3'b000,
    BAE_OP_ADDF   = 3'b001,
    BAE_OP_ANDF   = 3'b010,
    BAE_OP_ANDL   = 3'b011,
    BAE_OP_BCLR   = 3'b100
  } bae_op_t;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } bae_flags_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic          rd;
    logic          wr;
    logic [DW-1:0] wdata;
  } bae_file_req_t;

endpackage

// File: tb/byte_add_and_bitclear_exec_test.sv
// self-checking bench for the byte add / and / bit-clear datapath
// assumes bae_exec alone, inputs driven at the falling edge
`timescale 1ns/100ps

module byte_add_and_bitclear_exec_test;
  import bae_pkg::*;

  logic            ref_clk_i;
  logic            reset_i;
  logic [IW_W-1:0] instr_i;
  logic [DW-1:0]   file_rdata_i;
  logic [DW-1:0]   pins_a_i;
  logic [DW-1:0]   pins_b_i;
  bae_file_req_t   file_o;
  logic [DW-1:0]   acc_o;
  bae_flags_t      flags_o;
  logic [1:0]      phase_o;
  logic            done_o;
  int              num_errors;
  int              tests_run;
  int              cycles;

  bae_exec DUT (
    .ref_clk_i    (ref_clk_i),
    .reset_i      (reset_i),
    .instr_i      (instr_i),
    .file_rdata_i (file_rdata_i),
    .pins_a_i     (pins_a_i),
    .pins_b_i     (pins_b_i),
    .file_o       (file_o),
    .acc_o        (acc_o),
    .flags_o      (flags_o),
    .phase_o      (phase_o),
    .done_o       (done_o)
  );

  // ****************************************
  // clock, timeout, report
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // whole run is about 100 clocks
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR t=%0t %s", $time, msg);
    end
  endtask

  // ****************************************
  // one instruction cycle, entered at negedge in Q1
  // ****************************************
  task automatic run_op(input logic [IW_W-1:0] iw, input logic [DW-1:0] rdata,
                        input logic exp_rd, input logic exp_wr, input logic [DW-1:0] exp_wd,
                        input logic [DW-1:0] exp_acc, input logic [2:0] exp_fl);
    instr_i      = iw;
    file_rdata_i = rdata;
    @(negedge ref_clk_i);
    // garbage after Q1 must be ignored
    instr_i = ~iw;
    check(phase_o === PH_Q2 && file_o.rd === exp_rd && done_o === 1'b0, "read phase");
    if (exp_rd | exp_wr) check(file_o.addr === iw[ADDR_HI:0], "file address");
    @(negedge ref_clk_i);
    check(phase_o === PH_Q3 && file_o.rd === 1'b0 && file_o.wr === 1'b0, "compute phase");
    @(negedge ref_clk_i);
    check(phase_o === PH_Q4 && done_o === 1'b1 && file_o.wr === exp_wr, "write phase");
    if (exp_wr) check(file_o.wdata === exp_wd, $sformatf("wdata %h", file_o.wdata));
    @(negedge ref_clk_i);
    check(acc_o === exp_acc, $sformatf("acc %h want %h", acc_o, exp_acc));
    check(flags_o === exp_fl, $sformatf("flags %b want %b", flags_o, exp_fl));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check(acc_o === ACC_RST && flags_o === 3'h0, "reset acc/flags");
    check(phase_o === PH_Q1 && done_o === 1'b0 && file_o.wr === 1'b0, "reset phase");
  endtask

  task automatic t_mid_reset();
    // reset lands in Q3 of an add: nothing of it may be committed
    instr_i      = 14'h0720;
    file_rdata_i = 8'h01;
    @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_i = 1'b1;
    @(negedge ref_clk_i);
    check(acc_o === ACC_RST && flags_o === 3'h0, "mid-run reset acc/flags");
    check(phase_o === PH_Q1 && file_o.wr === 1'b0, "mid-run reset phase");
    reset_i = 1'b0;
    run_op(14'h0720, 8'h01, 1'b1, 1'b0, 8'h00, 8'h01, 3'h0);
  endtask

  task automatic t_add();
    run_op(14'h0720, 8'h17, 1'b1, 1'b0, 8'h00, 8'h17, 3'h0);
    run_op(14'h0720, 8'hC2, 1'b1, 1'b0, 8'h00, 8'hD9, 3'h0);
    run_op(14'h07A1, 8'h27, 1'b1, 1'b1, 8'h00, 8'hD9, 3'h7);
    run_op(14'h07A1, 8'h08, 1'b1, 1'b1, 8'hE1, 8'hD9, 3'h2);
  endtask

  task automatic t_and_file();
    // carry and half-carry must survive
    run_op(14'h05A2, 8'h26, 1'b1, 1'b1, 8'h00, 8'hD9, 3'h3);
    run_op(14'h0522, 8'hC2, 1'b1, 1'b0, 8'h00, 8'hC0, 3'h2);
  endtask

  task automatic t_and_lit();
    run_op(14'h394F, 8'hFF, 1'b0, 1'b0, 8'h00, 8'h40, 3'h2);
  endtask

  task automatic t_bit_clear();
    logic [IW_W-1:0] iw;
    for (int b = 0; b < 8; b++) begin
      iw = 14'h1030 | (IW_W'(b) << 7);
      run_op(iw, 8'hFF, 1'b1, 1'b1, 8'hFF & ~(8'h01 << b), 8'h40, 3'h2);
    end
  endtask

  task automatic t_port_read();
    // file data deliberately differs from the pins
    run_op(14'h0705, 8'hFF, 1'b0, 1'b0, 8'h00, 8'h9A, 3'h0);
    run_op(14'h0706, 8'h00, 1'b0, 1'b0, 8'h00, 8'h3F, 3'h4);
    // bit clear on port b writes back the pin level with bit 0 cleared
    run_op(14'h1006, 8'hFF, 1'b0, 1'b1, 8'hA4, 8'h3F, 3'h4);
  endtask

  task automatic t_noop();
    run_op(14'h2ABC, 8'h55, 1'b0, 1'b0, 8'h00, 8'h3F, 3'h4);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    num_errors   = 0;
    tests_run    = 0;
    cycles       = 0;
    reset_i      = 1'b1;
    instr_i      = 14'h0000;
    file_rdata_i = 8'h00;
    pins_a_i     = 8'h5A;
    pins_b_i     = 8'hA5;
    repeat (10) @(negedge ref_clk_i);
    t_reset();
    reset_i = 1'b0;
    t_add();
    t_and_file();
    t_and_lit();
    t_bit_clear();
    t_port_read();
    t_noop();
    t_mid_reset();
    final_report();
  end

endmodule
